// ===== rtl/bpt_pkg.sv
/*
 * Constants for the breathing pattern timing block: register map, field
 * positions, reset values and phase duration tables.
 * Assumes a 20 MHz core clock; durations are kept in milliseconds.
 */
package bpt_pkg;
    localparam int NUM_PAT = 3;
    localparam int REGS_PER_PAT = 4;
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TIME_W = 14;
    localparam int REP_W = 11;

    // Register offsets
    localparam logic [7:0] OFS_PAT1_RISE_ON = 8'h30;
    localparam logic [7:0] OFS_PAT1_FALL_OFF = 8'h31;
    localparam logic [7:0] OFS_PAT1_GAP_DELAY = 8'h32;
    localparam logic [7:0] OFS_PAT1_RUN_CTRL = 8'h33;
    localparam logic [7:0] OFS_PAT2_RISE_ON = 8'h35;
    localparam logic [7:0] OFS_PAT2_FALL_OFF = 8'h36;
    localparam logic [7:0] OFS_PAT2_GAP_DELAY = 8'h37;
    localparam logic [7:0] OFS_PAT2_RUN_CTRL = 8'h38;
    localparam logic [7:0] OFS_PAT3_RISE_ON = 8'h3a;
    localparam logic [7:0] OFS_PAT3_FALL_OFF = 8'h3b;
    localparam logic [7:0] OFS_PAT3_GAP_DELAY = 8'h3c;
    localparam logic [7:0] OFS_PAT3_RUN_CTRL = 8'h3d;

    localparam int IDX_RISE_ON = 0;
    localparam int IDX_FALL_OFF = 1;
    localparam int IDX_GAP_DELAY = 2;
    localparam int IDX_RUN_CTRL = 3;

    localparam logic [7:0] RST_PAT1_RISE_ON = 8'h80;
    localparam logic [7:0] RST_PAT1_FALL_OFF = 8'h86;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Field positions
    localparam int RISE_LSB = 4;
    localparam int ON_LSB = 0;
    localparam int FALL_LSB = 4;
    localparam int OFF_LSB = 0;
    localparam int GAP_LSB = 4;
    localparam int DELAY_LSB = 0;
    localparam int FINITE_BIT = 7;
    localparam int ADVANCE_BIT = 6;
    localparam int PULSES_LSB = 4;
    localparam int SLOT_EN_LSB = 0;
    localparam int REP_X16_BIT = 7;

    localparam logic [TIME_W-1:0] HOLD_MIN_MS = 14'h0028;
    localparam logic [3:0] REP_X16_FILL = 4'hf;

    function automatic logic [TIME_W-1:0] ramp_ms(input logic [3:0] code);
        case (code)
            4'h0: ramp_ms = 14'd0;
            4'h1: ramp_ms = 14'd130;
            4'h2: ramp_ms = 14'd260;
            4'h3: ramp_ms = 14'd380;
            4'h4: ramp_ms = 14'd510;
            4'h5: ramp_ms = 14'd770;
            4'h6: ramp_ms = 14'd1040;
            4'h7: ramp_ms = 14'd1600;
            4'h8: ramp_ms = 14'd2100;
            4'h9: ramp_ms = 14'd2600;
            4'ha: ramp_ms = 14'd3100;
            4'hb: ramp_ms = 14'd4200;
            4'hc: ramp_ms = 14'd5200;
            4'hd: ramp_ms = 14'd6200;
            4'he: ramp_ms = 14'd7300;
            default: ramp_ms = 14'd8300;
        endcase
    endfunction

    function automatic logic [TIME_W-1:0] hold_ms(input logic [3:0] code);
        hold_ms = (code == 4'h0) ? HOLD_MIN_MS : ramp_ms(code);
    endfunction

    function automatic logic [TIME_W-1:0] gap_ms(input logic [2:0] code);
        case (code)
            3'h0: gap_ms = 14'd0;
            3'h1: gap_ms = 14'd130;
            3'h2: gap_ms = 14'd260;
            3'h3: gap_ms = 14'd380;
            3'h4: gap_ms = 14'd540;
            3'h5: gap_ms = 14'd670;
            3'h6: gap_ms = 14'd800;
            default: gap_ms = 14'd1024;
        endcase
    endfunction

    // Decodes a register address to hit, pattern and register index
    function automatic logic [4:0] decode(input logic [7:0] addr);
        case (addr)
            OFS_PAT1_RISE_ON: decode = 5'h10;
            OFS_PAT1_FALL_OFF: decode = 5'h11;
            OFS_PAT1_GAP_DELAY: decode = 5'h12;
            OFS_PAT1_RUN_CTRL: decode = 5'h13;
            OFS_PAT2_RISE_ON: decode = 5'h14;
            OFS_PAT2_FALL_OFF: decode = 5'h15;
            OFS_PAT2_GAP_DELAY: decode = 5'h16;
            OFS_PAT2_RUN_CTRL: decode = 5'h17;
            OFS_PAT3_RISE_ON: decode = 5'h18;
            OFS_PAT3_FALL_OFF: decode = 5'h19;
            OFS_PAT3_GAP_DELAY: decode = 5'h1a;
            OFS_PAT3_RUN_CTRL: decode = 5'h1b;
            default: decode = 5'h00;
        endcase
    endfunction

    // Next enabled colour slot after cur, wrapping; slot 0 if none enabled
    function automatic logic [1:0] next_slot(input logic [3:0] en, input logic [1:0] cur);
        logic [1:0] cand;
        next_slot = 2'h0; // R9
        for (int k = 4; k >= 1; k--)
        begin
            cand = 2'(cur + 2'(k));
            if (en[cand])
            begin
                next_slot = cand; // R8
            end
        end
    endfunction

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_DELAY = 7'h02,
        ST_RISE  = 7'h04,
        ST_ON    = 7'h08,
        ST_FALL  = 7'h10,
        ST_OFF   = 7'h20,
        ST_GAP   = 7'h40
    } bpt_state_t;

    localparam int BIT_IDLE = 0;
    localparam int BIT_RISE = 2;
    localparam int BIT_ON = 3;
    localparam int BIT_FALL = 4;
endpackage

// ===== rtl/bpt_top.sv
/*
 * Three breathing pattern sequencers with their timing registers.
 * Assumes the serial slave outside gives single-cycle register writes,
 * run/stop strobes, the mode level and the repeat-count bytes.
 */
`timescale 1ns/1ps

// Functional notes
// R1: Rise/delay codes, zero is none, bits 7:4/3:0
// R2: On code zero is 0.04 s, else table
// R3: Fall like rise, off like on
// R4: Pulse gap from 3-bit code, bits 6:4
// R5: Bit 7 clear runs forever, set finite
// R6: Bit 6 advances pattern, true-colour only
// R7: Pulses per cycle are code plus one
// R8: Cleared colour bit masks that slot
// R9: No slot enabled shows first slot
// R10: Repeats low seven plus one, times sixteen when bit 7 is set
// R11: Delay, then rise-on-fall-off pulses with gaps
module bpt_top #(
    parameter int TICK_CYCLES = bpt_pkg::CLK_HZ / bpt_pkg::MS_PER_S
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [2:0] i_run,
    input wire logic [2:0] i_stop,
    input wire logic i_true_color_mode,
    input wire logic [7:0] i_repeat_count_1,
    input wire logic [7:0] i_repeat_count_2,
    input wire logic [7:0] i_repeat_count_3,
    output logic [7:0] o_reg_rdata,
    output logic [2:0] o_pattern_active,
    output logic [2:0] o_rise,
    output logic [2:0] o_on,
    output logic [2:0] o_fall,
    output logic [1:0] o_color_slot_1,
    output logic [1:0] o_color_slot_2,
    output logic [1:0] o_color_slot_3
);
    localparam int NP = bpt_pkg::NUM_PAT;
    localparam int TW = bpt_pkg::TIME_W;
    localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    if (TICK_CYCLES < 1)
    begin : g_bad_tick
        $error("TICK_CYCLES must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] regs [NP][bpt_pkg::REGS_PER_PAT];
    logic [7:0] next_regs [NP][bpt_pkg::REGS_PER_PAT];
    logic [7:0] next_rdata;
    logic [4:0] hit;

    always_comb
    begin
        hit = bpt_pkg::decode(i_reg_addr);
        next_regs = regs;
        next_rdata = 8'h00;
        if (hit[4])
        begin
            next_rdata = regs[hit[3:2]][hit[1:0]];
            if (i_reg_wr)
            begin
                next_regs[hit[3:2]][hit[1:0]] = i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            for (int p = 0; p < NP; p++)
            begin
                for (int r = 0; r < bpt_pkg::REGS_PER_PAT; r++)
                begin
                    regs[p][r] <= bpt_pkg::RST_ZERO;
                end
            end
            regs[0][bpt_pkg::IDX_RISE_ON] <= bpt_pkg::RST_PAT1_RISE_ON;
            regs[0][bpt_pkg::IDX_FALL_OFF] <= bpt_pkg::RST_PAT1_FALL_OFF;
            o_reg_rdata <= 8'h00;
        end
        else
        begin
            regs <= next_regs;
            o_reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick

    logic [PW-1:0] presc;
    logic [PW-1:0] next_presc;
    logic tick;

    always_comb
    begin
        tick = (presc == PW'(TICK_CYCLES - 1));
        next_presc = tick ? '0 : PW'(presc + 1'b1);
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            presc <= '0;
        end
        else
        begin
            presc <= next_presc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencers

    bpt_pkg::bpt_state_t state [NP];
    bpt_pkg::bpt_state_t next_state [NP];
    logic [TW-1:0] timer [NP];
    logic [TW-1:0] next_timer [NP];
    logic [1:0] pulse_cnt [NP];
    logic [1:0] next_pulse_cnt [NP];
    logic [bpt_pkg::REP_W-1:0] rep_cnt [NP];
    logic [bpt_pkg::REP_W-1:0] next_rep_cnt [NP];
    logic [1:0] slot [NP];
    logic [1:0] next_slot_q [NP];
    logic [7:0] rep_field [NP];

    assign rep_field[0] = i_repeat_count_1;
    assign rep_field[1] = i_repeat_count_2;
    assign rep_field[2] = i_repeat_count_3;

    always_comb
    begin
        logic [7:0] ro;
        logic [7:0] fo;
        logic [7:0] gd;
        logic [7:0] rc;
        logic [bpt_pkg::REP_W-1:0] last;
        logic [NP-1:0] chain;
        logic done;
        ro = 8'h00;
        fo = 8'h00;
        gd = 8'h00;
        rc = 8'h00;
        last = '0;
        chain = '0;
        done = 1'b0;
        for (int p = 0; p < NP; p++)
        begin
            ro = regs[p][bpt_pkg::IDX_RISE_ON];
            fo = regs[p][bpt_pkg::IDX_FALL_OFF];
            gd = regs[p][bpt_pkg::IDX_GAP_DELAY];
            rc = regs[p][bpt_pkg::IDX_RUN_CTRL];
            last = rep_field[p][bpt_pkg::REP_X16_BIT]
                ? {rep_field[p][6:0], bpt_pkg::REP_X16_FILL}
                : {4'h0, rep_field[p][6:0]}; // R10
            done = (timer[p] == '0);
            next_state[p] = state[p];
            next_pulse_cnt[p] = pulse_cnt[p];
            next_rep_cnt[p] = rep_cnt[p];
            next_slot_q[p] = slot[p];
            next_timer[p] = (tick && !done) ? TW'(timer[p] - 1'b1) : timer[p];
            case (state[p])
                bpt_pkg::ST_IDLE:
                begin
                    next_timer[p] = '0;
                end
                bpt_pkg::ST_DELAY, bpt_pkg::ST_GAP:
                begin
                    if (done)
                    begin
                        next_state[p] = bpt_pkg::ST_RISE; // R11
                        next_timer[p] = bpt_pkg::ramp_ms(ro[bpt_pkg::RISE_LSB+:4]); // R1
                    end
                end
                bpt_pkg::ST_RISE:
                begin
                    if (done)
                    begin
                        next_state[p] = bpt_pkg::ST_ON; // R11
                        next_timer[p] = bpt_pkg::hold_ms(ro[bpt_pkg::ON_LSB+:4]); // R2
                    end
                end
                bpt_pkg::ST_ON:
                begin
                    if (done)
                    begin
                        next_state[p] = bpt_pkg::ST_FALL; // R11
                        next_timer[p] = bpt_pkg::ramp_ms(fo[bpt_pkg::FALL_LSB+:4]); // R3
                    end
                end
                bpt_pkg::ST_FALL:
                begin
                    if (done)
                    begin
                        next_state[p] = bpt_pkg::ST_OFF; // R11
                        next_timer[p] = bpt_pkg::hold_ms(fo[bpt_pkg::OFF_LSB+:4]); // R3
                    end
                end
                bpt_pkg::ST_OFF:
                begin
                    if (done && pulse_cnt[p] != rc[bpt_pkg::PULSES_LSB+:2])
                    begin
                        next_pulse_cnt[p] = 2'(pulse_cnt[p] + 1'b1); // R7
                        next_state[p] = bpt_pkg::ST_GAP;
                        next_timer[p] = bpt_pkg::gap_ms(gd[bpt_pkg::GAP_LSB+:3]); // R4
                    end
                    else if (done && rc[bpt_pkg::FINITE_BIT] && rep_cnt[p] == last)
                    begin
                        next_state[p] = bpt_pkg::ST_IDLE; // R5
                        chain[(p + 1) % NP] = rc[bpt_pkg::ADVANCE_BIT] & i_true_color_mode; // R6
                    end
                    else if (done)
                    begin
                        // Counter only advances in finite mode so it cannot wrap
                        if (rc[bpt_pkg::FINITE_BIT])
                        begin
                            next_rep_cnt[p] = bpt_pkg::REP_W'(rep_cnt[p] + 1'b1); // R5
                        end
                        next_pulse_cnt[p] = 2'h0;
                        next_slot_q[p] = bpt_pkg::next_slot(rc[bpt_pkg::SLOT_EN_LSB+:4], slot[p]);
                        next_state[p] = bpt_pkg::ST_DELAY; // R11
                        next_timer[p] = bpt_pkg::ramp_ms(gd[bpt_pkg::DELAY_LSB+:4]); // R1
                    end
                end
                default:
                begin
                    next_state[p] = bpt_pkg::ST_IDLE;
                end
            endcase
        end
        for (int p = 0; p < NP; p++)
        begin
            rc = regs[p][bpt_pkg::IDX_RUN_CTRL];
            gd = regs[p][bpt_pkg::IDX_GAP_DELAY];
            if (i_stop[p])
            begin
                next_state[p] = bpt_pkg::ST_IDLE;
            end
            else if (i_run[p] || chain[p])
            begin
                next_state[p] = bpt_pkg::ST_DELAY; // R11
                next_timer[p] = bpt_pkg::ramp_ms(gd[bpt_pkg::DELAY_LSB+:4]); // R1
                next_pulse_cnt[p] = 2'h0;
                next_rep_cnt[p] = '0;
                next_slot_q[p] = bpt_pkg::next_slot(rc[bpt_pkg::SLOT_EN_LSB+:4], 2'h3); // R8 R9
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            for (int p = 0; p < NP; p++)
            begin
                state[p] <= bpt_pkg::ST_IDLE;
                timer[p] <= '0;
                pulse_cnt[p] <= 2'h0;
                rep_cnt[p] <= '0;
                slot[p] <= 2'h0;
            end
        end
        else
        begin
            state <= next_state;
            timer <= next_timer;
            pulse_cnt <= next_pulse_cnt;
            rep_cnt <= next_rep_cnt;
            slot <= next_slot_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, straight from state and slot flops

    always_comb
    begin
        for (int p = 0; p < NP; p++)
        begin
            o_pattern_active[p] = ~state[p][bpt_pkg::BIT_IDLE];
            o_rise[p] = state[p][bpt_pkg::BIT_RISE];
            o_on[p] = state[p][bpt_pkg::BIT_ON];
            o_fall[p] = state[p][bpt_pkg::BIT_FALL];
        end
    end

    assign o_color_slot_1 = slot[0];
    assign o_color_slot_2 = slot[1];
    assign o_color_slot_3 = slot[2];
endmodule

// ===== testbench/bpt_top_props.sv
/* Port checker for bpt_top, tracing pattern 1 and its hand-over to pattern 2.
   Assumes it is bound onto bpt_top, with register writes only while idle. */
`timescale 1ns/1ps
module bpt_props #(
    parameter int TICK_CYCLES = 2
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [2:0] i_run,
    input wire logic [2:0] i_stop,
    input wire logic i_true_color_mode,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [2:0] o_pattern_active,
    input wire logic [2:0] o_rise,
    input wire logic [2:0] o_on,
    input wire logic [2:0] o_fall,
    input wire logic [1:0] o_color_slot_1
);
    logic fin1;
    logic [3:0] en1;
    // Shadow of the pattern 1 run control bits
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            fin1 <= 1'b0;
            en1 <= 4'h0;
        end
        else if (i_reg_wr && i_reg_addr == 8'h33)
        begin
            fin1 <= i_reg_wdata[7];
            en1 <= i_reg_wdata[3:0];
        end
    end
    function automatic logic [1:0] first_slot(input logic [3:0] e);
        first_slot = e[0] ? 2'h0 : e[1] ? 2'h1 : e[2] ? 2'h2 : e[3] ? 2'h3 : 2'h0;
    endfunction
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////////////////////////////////////////
    property p_unmapped;
        i_reg_addr == 8'h34 |=> o_reg_rdata == 8'h00;
    endproperty
    property p_wr_rd;
        (i_reg_wr && i_reg_addr == 8'h30) ##1 ($stable(i_reg_addr) && !i_reg_wr)
            |=> o_reg_rdata == $past(i_reg_wdata, 2);
    endproperty
    property p_onehot;
        $onehot0({o_rise[0], o_on[0], o_fall[0]});
    endproperty
    property p_rise_on;
        $fell(o_rise[0]) && !$past(i_stop[0]) && !$past(i_run[0]) |-> o_on[0];
    endproperty
    property p_on_fall;
        $fell(o_on[0]) && !$past(i_stop[0]) && !$past(i_run[0]) |-> o_fall[0];
    endproperty
    property p_on_min;
        $rose(o_on[0]) ##0 (!i_stop[0] && !i_run[0]) [*7] |=> o_on[0];
    endproperty
    property p_fin;
        $fell(o_pattern_active[0]) && !$past(i_stop[0]) |-> $past(fin1);
    endproperty
    property p_chain;
        $rose(o_pattern_active[1]) && !$past(i_run[1])
            |-> $fell(o_pattern_active[0]) && $past(i_true_color_mode);
    endproperty
    property p_slot;
        $rose(o_pattern_active[0]) |-> o_color_slot_1 == first_slot($past(en1));
    endproperty
    property p_stop;
        i_stop[0] |=> !o_pattern_active[0] && !o_rise[0];
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_wr_rd: assert property (p_wr_rd) else $error("write not read back");
    a_onehot: assert property (p_onehot) else $error("two phases at once");
    a_rise_on: assert property (p_rise_on) else $error("rise not followed by on");
    a_on_fall: assert property (p_on_fall) else $error("on not followed by fall");
    a_on_min: assert property (p_on_min) else $error("on phase too short");
    a_fin: assert property (p_fin) else $error("endless pattern finished");
    a_chain: assert property (p_chain) else $error("bad pattern hand-over");
    a_slot: assert property (p_slot) else $error("wrong start slot");
    a_stop: assert property (p_stop) else $error("stop ignored");
    c_chain: cover property ($rose(o_pattern_active[1]) && !$past(i_run[1]));
    c_fin: cover property ($fell(o_pattern_active[0]) && !$past(i_stop[0]));
    c_on: cover property ($rose(o_on[0]));
endmodule
bind bpt_top bpt_props #(.TICK_CYCLES(TICK_CYCLES)) u_bpt_props (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_run(i_run), .i_stop(i_stop),
    .i_true_color_mode(i_true_color_mode), .o_reg_rdata(o_reg_rdata),
    .o_pattern_active(o_pattern_active), .o_rise(o_rise), .o_on(o_on), .o_fall(o_fall),
    .o_color_slot_1(o_color_slot_1));

// ===== testbench/bpt_host.sv
/* Host model: byte register writes and reads on the falling edge.
   Assumes the read data follows the address one clock later. */
`timescale 1ns/1ps
module bpt_host (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial
    begin
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clk);
        o_wr = 1'b0;
        // Stale data inverted so a late capture shows up
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        @(negedge i_clk);
        d = i_rdata;
    endtask
endmodule

// ===== testbench/bpt_top_tb.sv
/* Self-checking bench for bpt_top with a shortened millisecond tick.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module bpt_top_tb;
    localparam int TICK = 2;
    logic clk, arst_n, wr, tcm;
    logic [7:0] addr, wdata, rdata, rep1;
    logic [2:0] run, stop, act, rise, on, fall;
    logic [1:0] s1, s2, s3;
    logic rq = 1'b0;
    logic oq = 1'b0;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0, rise_n = 0, rs_prev = 0, rs_last = 0, re = 0, os = 0, oe = 0;
    bpt_top #(.TICK_CYCLES(TICK)) u_bpt_top (.i_clk(clk), .i_arst_n(arst_n),
        .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_run(run),
        .i_stop(stop), .i_true_color_mode(tcm), .i_repeat_count_1(rep1),
        .i_repeat_count_2(8'h00), .i_repeat_count_3(8'h00), .o_reg_rdata(rdata),
        .o_pattern_active(act), .o_rise(rise), .o_on(on), .o_fall(fall),
        .o_color_slot_1(s1), .o_color_slot_2(s2), .o_color_slot_3(s3));
    bpt_host u_bpt_host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_addr(addr),
        .o_wdata(wdata));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Phase edge stamps of pattern 1, in clock cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        rq <= rise[0];
        oq <= on[0];
        if (rise[0] && !rq)
        begin
            rise_n <= rise_n + 1;
            rs_prev <= rs_last;
            rs_last <= cyc;
        end
        if (!rise[0] && rq) re <= cyc;
        if (on[0] && !oq) os <= cyc;
        if (!on[0] && oq) oe <= cyc;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic in_r(input int v, input int c, input int t);
        in_r = (v >= c - t) && (v <= c + t);
    endfunction
    task automatic cfg(input logic [7:0] a, b, c, d);
        u_bpt_host.wr(8'h30, a);
        u_bpt_host.wr(8'h31, b);
        u_bpt_host.wr(8'h32, c);
        u_bpt_host.wr(8'h33, d);
    endtask
    task automatic start();
        @(negedge clk);
        run[0] = 1'b1;
        @(negedge clk);
        run[0] = 1'b0;
    endtask
    task automatic pulse_stop(input int p);
        stop[p] = 1'b1;
        @(negedge clk);
        stop[p] = 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (act[0] === 1'b1 && n < 20000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 20000)
        begin
            bad_count++;
            $display("[FAIL] %0t pattern never finished", $time);
            final_report();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] a, d;
        for (int i = 0; i < 12; i++)
        begin
            a = 8'h30 + 8'(i + i / 4);
            u_bpt_host.rd(a, d);
            chk(d, (i == 0) ? 8'h80 : (i == 1) ? 8'h86 : 8'h00);
            u_bpt_host.wr(a, a ^ 8'h5a);
            u_bpt_host.rd(a, d);
            chk(d, a ^ 8'h5a);
            u_bpt_host.wr(a, 8'h00);
        end
        u_bpt_host.wr(8'h34, 8'hff);
        u_bpt_host.rd(8'h34, d);
        chk(d, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_counts();
        int n0;
        for (int c = 0; c < 6; c++)
        begin
            cfg(8'h00, 8'h00, 8'h00, 8'h81 | ((c < 4) ? 8'(c << 4) : 8'h00));
            rep1 = (c == 4) ? 8'h02 : (c == 5) ? 8'h81 : 8'h00;
            n0 = rise_n;
            start();
            wait_idle();
            chk(rise_n - n0, (c < 4) ? c + 1 : (c == 4) ? 3 : 32);
        end
        $display("t_counts done");
    endtask
    task automatic t_timing();
        int t0;
        cfg(8'h10, 8'h00, 8'h11, 8'h91);
        rep1 = 8'h00;
        t0 = cyc;
        start();
        wait_idle();
        chk(in_r(rs_prev - t0, 263, 8), 1'b1);
        chk(in_r(re - rs_last, 261, 3), 1'b1);
        chk(in_r(oe - os, 81, 3), 1'b1);
        chk(in_r(rs_last - rs_prev, 685, 10), 1'b1);
        $display("t_timing done");
    endtask
    task automatic t_modes();
        cfg(8'h00, 8'h00, 8'h00, 8'h01);
        start();
        repeat (400) @(negedge clk);
        chk(act[0], 1'b1);
        pulse_stop(0);
        chk(act[0], 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            cfg(8'h00, 8'h00, 8'h00, k ? 8'h80 : 8'h84);
            start();
            chk(s1, k ? 2'h0 : 2'h2);
            pulse_stop(0);
        end
        u_bpt_host.wr(8'h38, 8'h04);
        for (int k = 0; k < 2; k++)
        begin
            tcm = (k == 0);
            cfg(8'h00, 8'h00, 8'h00, 8'hc1);
            start();
            wait_idle();
            chk(act[1], (k == 0));
            if (k == 0) chk(s2, 2'h2);
            pulse_stop(1);
        end
        u_bpt_host.wr(8'h3d, 8'h08);
        @(negedge clk);
        run[2] = 1'b1;
        @(negedge clk);
        run[2] = 1'b0;
        chk({act[2], s3}, 3'h7);
        pulse_stop(2);
        $display("t_modes done");
    endtask
    initial
    begin
        arst_n = 1'b0;
        run = 3'h0;
        stop = 3'h0;
        tcm = 1'b0;
        rep1 = 8'h00;
        repeat (4) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_regs();
        t_counts();
        t_timing();
        t_modes();
        final_report();
    end
endmodule
